// >>> src/uotg_consts.vh
/*
  Constants for the USB OTG status, power and flag block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 20 MHz pclk; included by bare name from the design file.
*/
`ifndef UOTG_CONSTS_VH
`define UOTG_CONSTS_VH

// Register byte offsets on the APB
`define UOTG_ADDR_W 4
`define UOTG_OFS_LINE_STATUS 4'h0
`define UOTG_OFS_LINE_CONTROL 4'h4
`define UOTG_OFS_POWER_CONTROL 4'h8
`define UOTG_OFS_FLAGS 4'hc

// Line status fields
`define UOTG_ST_IDENT 7
`define UOTG_ST_LSTABLE 5
`define UOTG_ST_SESVALID 3
`define UOTG_ST_B_SESSION_END_STATUS 2
`define UOTG_ST_VBUSVALID 0

// Line control fields
`define UOTG_CT_DPPU 7
`define UOTG_CT_DMPU 6
`define UOTG_CT_DPPD 5
`define UOTG_CT_DMPD 4
`define UOTG_CT_VBUS_POWER_ON 3
`define UOTG_CT_SWCTL 2
`define UOTG_CT_CHG 1
`define UOTG_CT_DIS 0
`define UOTG_CT_MASK 8'hff

// Power control fields
`define UOTG_PW_ACTPND 7
`define UOTG_PW_GUARD 4
`define UOTG_PW_BUSY 3
`define UOTG_PW_SUSP 1
`define UOTG_PW_OPEN 0
`define UOTG_PW_MASK 8'h13

// Flag fields
`define UOTG_FL_STALL 7
`define UOTG_FL_ATTACH 6
`define UOTG_FL_RESUME 5
`define UOTG_FL_IDLE 4
`define UOTG_FL_TOKEN 3
`define UOTG_FL_SOF 2
`define UOTG_FL_ERROR 1
`define UOTG_FL_RSTDET 0

`define UOTG_RST_BYTE 8'h00

// Times and counts at 20 MHz
`define UOTG_CLK_HZ 20000000
`define UOTG_STABLE_US 1000
`define UOTG_QUIET_NS 2500
`define UOTG_IDLE_US 3000
`define UOTG_STABLE_CYC ((`UOTG_STABLE_US * (`UOTG_CLK_HZ / 1000000)))
`define UOTG_QUIET_CYC ((`UOTG_QUIET_NS * (`UOTG_CLK_HZ / 1000000) + 999) / 1000)
`define UOTG_IDLE_CYC ((`UOTG_IDLE_US * (`UOTG_CLK_HZ / 1000000)))
`define UOTG_CNT_W 17
`define UOTG_BUSY_CYC 8'h04

`endif

// >>> src/uotg_status_power.v
/*
  USB OTG control and status logic: line status, line resistor and VBUS
  controls, power/suspend gating and the main event flags, behind APB.
  Assumes event inputs are single-cycle pulses synchronous to pclk and line
  indications already synchronised to pclk.
*/
// Function
// RULE1 - Identity bit reads 1 with no cable or B cable, 0 with A cable
// RULE2 - Line-stable bit set only after single-ended zero and J unchanged for 1 ms
// RULE3 - Session-valid bit follows VBUS above session-valid, A or B role
// RULE4 - As B-device, session-end bit set while VBUS below session-valid
// RULE5 - As A-device, VBUS-valid bit set while VBUS above session-valid
// RULE6 - Four resistor enables for D+/D- pull-ups and pull-downs, 1 connects
// RULE7 - Software line control on: resistors follow register, else hardware
// RULE8 - Separate VBUS charge and discharge controls, active at 1
// RULE9 - Activity-pending set by hardware while activity seen, flag not yet raised
// RULE10 - Sleep guard on blocks sleep during activity or pending flag
// RULE11 - Busy shows active, or disabled and not yet ready to re-enable
// RULE12 - Suspend gates the 48 MHz clock and idles the transceiver
// RULE13 - Operation disabled holds outputs inactive and releases the pins (sleep_block and status_fifo_advance are not gated by the enable)
// RULE14 - STALL flag on received STALL as host, sent STALL as device
// RULE15 - Attach flag needs host mode, 2.5 us quiet bus, not single-ended zero
// RULE16 - Resume flag after K-state present for 2.5 us
// RULE17 - Software keeps resume interrupt disabled outside suspend
// RULE18 - Idle flag after 3 ms or more of continuous idle bus
// RULE19 - Token-done flag on token finish; clearing it advances status FIFO
// RULE20 - SOF flag on received SOF as device, threshold reached as host
// RULE21 - Error summary flag only for error with its enable set
// RULE22 - Flag bit 0 is bus reset as device, detach as host
`timescale 1ns/1ns
`default_nettype none
`include "uotg_consts.vh"

module uotg_status_power
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cable_identity,
  input wire vbus_above_session,
  input wire a_device_role,
  input wire single_ended_zero,
  input wire j_state_indication,
  input wire k_state_indication,
  input wire host_mode_enable,
  input wire bus_activity,
  input wire hw_dplus_pullup,
  input wire hw_dminus_pullup,
  input wire hw_dplus_pulldown,
  input wire hw_dminus_pulldown,
  input wire stall_handshake,
  input wire token_finished,
  input wire sof_received,
  input wire sof_threshold,
  input wire [7:0] error_events,
  input wire [7:0] error_enables,
  input wire bus_reset_seen,
  input wire detach_seen,
  output reg dplus_pullup_en,
  output reg dminus_pullup_en,
  output reg dplus_pulldown_en,
  output reg dminus_pulldown_en,
  output reg vbus_power_on,
  output reg vbus_charge_en,
  output reg vbus_discharge_en,
  output reg usb_clk_enable,
  output reg xcvr_low_power,
  output reg pins_owned,
  output reg sleep_block,
  output reg status_fifo_advance
);

  localparam ST_OFF = 3'b001;
  localparam ST_ON = 3'b010;
  localparam ST_DRAIN = 3'b100;

  reg [7:0] line_ctrl;
  reg sleep_entry_guard;
  reg suspend_ctrl;
  reg operation_enable;
  reg [7:0] flags;
  reg [2:0] pstate;
  reg [7:0] drain_cnt;
  reg [`UOTG_CNT_W-1:0] stable_cnt;
  reg [`UOTG_CNT_W-1:0] quiet_cnt;
  reg [`UOTG_CNT_W-1:0] k_cnt;
  reg [`UOTG_CNT_W-1:0] idle_cnt;
  reg prev_se0;
  reg prev_j;
  reg line_state_stable;
  reg attach_armed;
  reg resume_armed;
  reg idle_armed;
  reg activity_pending;
  reg [7:0] next_flags;
  reg [7:0] flag_set;
  reg [31:0] rd_word;

  wire module_busy;
  wire wr_xfer;
  wire [7:0] wbyte;
  wire idle_bus;

  // Register select shared by write and read paths
  function sel_reg;
    input [31:0] addr;
    input [`UOTG_ADDR_W-1:0] ofs;
    begin
      sel_reg = (addr[31:`UOTG_ADDR_W] == {(32-`UOTG_ADDR_W){1'b0}}) &&
                (addr[`UOTG_ADDR_W-1:0] == ofs);
    end
  endfunction

  // Mapped address test, unmapped answers with pslverr
  function is_mapped;
    input [31:0] addr;
    begin
      is_mapped = sel_reg(addr, `UOTG_OFS_LINE_STATUS) |
                  sel_reg(addr, `UOTG_OFS_LINE_CONTROL) |
                  sel_reg(addr, `UOTG_OFS_POWER_CONTROL) |
                  sel_reg(addr, `UOTG_OFS_FLAGS);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign wr_xfer = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];
  assign idle_bus = j_state_indication & ~single_ended_zero;
  assign module_busy = (pstate != ST_OFF); // [RULE11]

  // Power sequencing: after disable, the block drains before re-enable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pstate <= ST_OFF;
      drain_cnt <= 8'h00;
    end
    else
    begin
      case (pstate)
        ST_OFF:
        begin
          drain_cnt <= 8'h00;
          if (operation_enable)
            pstate <= ST_ON;
        end
        ST_ON:
        begin
          drain_cnt <= 8'h00;
          if (!operation_enable)
            pstate <= ST_DRAIN; // [RULE11]
        end
        ST_DRAIN:
        begin
          drain_cnt <= drain_cnt + 8'h01;
          if (drain_cnt == `UOTG_BUSY_CYC - 8'h01)
            pstate <= ST_OFF;
        end
        default:
        begin
          pstate <= ST_OFF;
          drain_cnt <= 8'h00;
        end
      endcase
    end
  end

  // Software-written registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_ctrl <= `UOTG_RST_BYTE;
      sleep_entry_guard <= 1'b0;
      suspend_ctrl <= 1'b0;
      operation_enable <= 1'b0;
    end
    else if (wr_xfer)
    begin
      if (sel_reg(paddr, `UOTG_OFS_LINE_CONTROL))
        line_ctrl <= wbyte & `UOTG_CT_MASK;
      if (sel_reg(paddr, `UOTG_OFS_POWER_CONTROL))
      begin
        sleep_entry_guard <= wbyte[`UOTG_PW_GUARD];
        suspend_ctrl <= wbyte[`UOTG_PW_SUSP];
        operation_enable <= wbyte[`UOTG_PW_OPEN];
      end
    end
  end

  // Line state stability over 1 ms
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_se0 <= 1'b0;
      prev_j <= 1'b1;
      stable_cnt <= {`UOTG_CNT_W{1'b0}};
      line_state_stable <= 1'b0;
    end
    else
    begin
      prev_se0 <= single_ended_zero;
      prev_j <= j_state_indication;
      if ((prev_se0 != single_ended_zero) || (prev_j != j_state_indication))
      begin
        stable_cnt <= {`UOTG_CNT_W{1'b0}};
        line_state_stable <= 1'b0; // [RULE2]
      end
      else if (stable_cnt == `UOTG_STABLE_CYC - 1)
        line_state_stable <= 1'b1; // [RULE2]
      else
        stable_cnt <= stable_cnt + {{(`UOTG_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Quiet, K-state and idle timers for attach, resume and idle detection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_cnt <= {`UOTG_CNT_W{1'b0}};
      k_cnt <= {`UOTG_CNT_W{1'b0}};
      idle_cnt <= {`UOTG_CNT_W{1'b0}};
      attach_armed <= 1'b1;
      resume_armed <= 1'b1;
      idle_armed <= 1'b1;
    end
    else
    begin
      if (bus_activity || single_ended_zero)
      begin
        quiet_cnt <= {`UOTG_CNT_W{1'b0}};
        attach_armed <= 1'b1;
      end
      else if (quiet_cnt != `UOTG_QUIET_CYC)
        quiet_cnt <= quiet_cnt + {{(`UOTG_CNT_W-1){1'b0}}, 1'b1};
      else
        attach_armed <= 1'b0;
      if (!k_state_indication)
      begin
        k_cnt <= {`UOTG_CNT_W{1'b0}};
        resume_armed <= 1'b1;
      end
      else if (k_cnt != `UOTG_QUIET_CYC)
        k_cnt <= k_cnt + {{(`UOTG_CNT_W-1){1'b0}}, 1'b1};
      else
        resume_armed <= 1'b0;
      if (!idle_bus)
      begin
        idle_cnt <= {`UOTG_CNT_W{1'b0}};
        idle_armed <= 1'b1;
      end
      else if (idle_cnt != `UOTG_IDLE_CYC)
        idle_cnt <= idle_cnt + {{(`UOTG_CNT_W-1){1'b0}}, 1'b1};
      else
        idle_armed <= 1'b0;
    end
  end

  // Flag sources; each fires once per qualifying condition
  always @*
  begin
    flag_set = 8'h00;
    flag_set[`UOTG_FL_STALL] = stall_handshake; // [RULE14]
    flag_set[`UOTG_FL_ATTACH] = host_mode_enable & attach_armed & ~single_ended_zero &
                                (quiet_cnt == `UOTG_QUIET_CYC); // [RULE15]
    flag_set[`UOTG_FL_RESUME] = resume_armed & (k_cnt == `UOTG_QUIET_CYC); // [RULE16]
    flag_set[`UOTG_FL_IDLE] = idle_armed & (idle_cnt == `UOTG_IDLE_CYC); // [RULE18]
    flag_set[`UOTG_FL_TOKEN] = token_finished; // [RULE19]
    flag_set[`UOTG_FL_SOF] = host_mode_enable ? sof_threshold : sof_received; // [RULE20]
    flag_set[`UOTG_FL_ERROR] = |(error_events & error_enables); // [RULE21]
    flag_set[`UOTG_FL_RSTDET] = host_mode_enable ? detach_seen : bus_reset_seen; // [RULE22]
    if (!operation_enable)
      flag_set = 8'h00;
  end

  // Write one to clear; a set in the same cycle wins
  always @*
  begin
    next_flags = flags;
    if (wr_xfer && sel_reg(paddr, `UOTG_OFS_FLAGS))
      next_flags = flags & ~wbyte;
    next_flags = next_flags | flag_set;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags <= `UOTG_RST_BYTE;
      activity_pending <= 1'b0;
      status_fifo_advance <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      activity_pending <= bus_activity & operation_enable & ~(|flag_set); // [RULE9]
      status_fifo_advance <= wr_xfer & sel_reg(paddr, `UOTG_OFS_FLAGS) &
                             wbyte[`UOTG_FL_TOKEN] & flags[`UOTG_FL_TOKEN]; // [RULE19]
    end
  end

  // Pin-facing outputs, registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dplus_pullup_en <= 1'b0;
      dminus_pullup_en <= 1'b0;
      dplus_pulldown_en <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      vbus_power_on <= 1'b0;
      vbus_charge_en <= 1'b0;
      vbus_discharge_en <= 1'b0;
      usb_clk_enable <= 1'b0;
      xcvr_low_power <= 1'b1;
      pins_owned <= 1'b0;
      sleep_block <= 1'b0;
    end
    else
    begin
      if (!operation_enable)
      begin
        dplus_pullup_en <= 1'b0; // [RULE13]
        dminus_pullup_en <= 1'b0;
        dplus_pulldown_en <= 1'b0;
        dminus_pulldown_en <= 1'b0;
        vbus_power_on <= 1'b0;
        vbus_charge_en <= 1'b0;
        vbus_discharge_en <= 1'b0;
      end
      else if (line_ctrl[`UOTG_CT_SWCTL])
      begin
        dplus_pullup_en <= line_ctrl[`UOTG_CT_DPPU]; // [RULE6] [RULE7]
        dminus_pullup_en <= line_ctrl[`UOTG_CT_DMPU];
        dplus_pulldown_en <= line_ctrl[`UOTG_CT_DPPD];
        dminus_pulldown_en <= line_ctrl[`UOTG_CT_DMPD];
        vbus_power_on <= line_ctrl[`UOTG_CT_VBUS_POWER_ON];
        vbus_charge_en <= line_ctrl[`UOTG_CT_CHG]; // [RULE8]
        vbus_discharge_en <= line_ctrl[`UOTG_CT_DIS];
      end
      else
      begin
        dplus_pullup_en <= hw_dplus_pullup; // [RULE7]
        dminus_pullup_en <= hw_dminus_pullup;
        dplus_pulldown_en <= hw_dplus_pulldown;
        dminus_pulldown_en <= hw_dminus_pulldown;
        vbus_power_on <= line_ctrl[`UOTG_CT_VBUS_POWER_ON];
        vbus_charge_en <= line_ctrl[`UOTG_CT_CHG]; // [RULE8]
        vbus_discharge_en <= line_ctrl[`UOTG_CT_DIS];
      end
      usb_clk_enable <= operation_enable & ~suspend_ctrl; // [RULE12] [RULE13]
      xcvr_low_power <= ~operation_enable | suspend_ctrl; // [RULE12]
      pins_owned <= operation_enable; // [RULE13]
      sleep_block <= sleep_entry_guard & (bus_activity | activity_pending |
                     (|flags)); // [RULE10]
    end
  end

  // Read mux
  always @*
  begin
    rd_word = 32'h00000000;
    if (sel_reg(paddr, `UOTG_OFS_LINE_STATUS))
    begin
      rd_word[`UOTG_ST_IDENT] = cable_identity; // [RULE1]
      rd_word[`UOTG_ST_LSTABLE] = line_state_stable;
      rd_word[`UOTG_ST_SESVALID] = vbus_above_session; // [RULE3]
      rd_word[`UOTG_ST_B_SESSION_END_STATUS] = ~a_device_role & ~vbus_above_session; // [RULE4]
      rd_word[`UOTG_ST_VBUSVALID] = a_device_role & vbus_above_session; // [RULE5]
    end
    else if (sel_reg(paddr, `UOTG_OFS_LINE_CONTROL))
      rd_word[7:0] = line_ctrl;
    else if (sel_reg(paddr, `UOTG_OFS_POWER_CONTROL))
    begin
      rd_word[`UOTG_PW_ACTPND] = activity_pending; // [RULE9]
      rd_word[`UOTG_PW_GUARD] = sleep_entry_guard;
      rd_word[`UOTG_PW_BUSY] = module_busy; // [RULE11]
      rd_word[`UOTG_PW_SUSP] = suspend_ctrl;
      rd_word[`UOTG_PW_OPEN] = operation_enable;
    end
    else if (sel_reg(paddr, `UOTG_OFS_FLAGS))
      rd_word[7:0] = flags;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_word;
  end

endmodule // uotg_status_power
`default_nettype wire

// >>> dv/uotg_sp_asserts.sv
/* Checker of port-level timing for the status/power block.
   Assumes the APB map 0x0/0x4/0x8/0xc and registered outputs. */
`timescale 1ns/1ns
`default_nettype none
module uotg_sp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic cable_identity,
  input wire logic vbus_above_session,
  input wire logic a_device_role,
  input wire logic dplus_pullup_en,
  input wire logic vbus_charge_en,
  input wire logic vbus_discharge_en,
  input wire logic usb_clk_enable,
  input wire logic pins_owned,
  input wire logic sleep_block,
  input wire logic status_fifo_advance
);
  logic [7:0] ctl;
  logic [4:0] pwr;
  wire wr = psel && penable && pwrite;
  wire tokw = wr && paddr == 32'hc && pwdata[3];
  // Shadow of the line and power registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl <= 8'h00;
      pwr <= 5'h00;
    end
    else if (wr && paddr == 32'h4)
      ctl <= pwdata[7:0];
    else if (wr && paddr == 32'h8)
      pwr <= pwdata[4:0];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_st;
    psel && !penable && !pwrite && paddr == 32'h0;
  endsequence
  sequence wr_ctl;
    wr && paddr == 32'h4 && pwdata[2] && pwr[0];
  endsequence
  AST_ID:
    assert property (rd_st |=> prdata[7] == $past(cable_identity))
    else $error("identity bit wrong");
  AST_SES:
    assert property (rd_st |=> prdata[3] == $past(vbus_above_session))
    else $error("session valid bit wrong");
  AST_END:
    assert property (rd_st |=> prdata[2] == !($past(vbus_above_session) || $past(a_device_role))
      && prdata[0] == ($past(vbus_above_session) && $past(a_device_role)))
    else $error("role dependent vbus bits wrong");
  AST_SW:
    assert property (wr_ctl |-> ##2 dplus_pullup_en == $past(pwdata[7], 2))
    else $error("pull-up does not follow software");
  AST_VBUS:
    assert property (1'b1 |=> vbus_charge_en == ($past(ctl[1]) && $past(pwr[0]))
      && vbus_discharge_en == ($past(ctl[0]) && $past(pwr[0])))
    else $error("vbus controls wrong");
  AST_OFF:
    assert property (!pwr[0] |=> !pins_owned && !usb_clk_enable && !dplus_pullup_en)
    else $error("outputs active while disabled");
  AST_SUSP:
    assert property (pwr[0] |=> usb_clk_enable == !$past(pwr[1]))
    else $error("usb clock gating wrong");
  AST_SLEEP:
    assert property (!pwr[4] |=> !sleep_block)
    else $error("sleep blocked without guard");
  AST_TOKEN:
    assert property (status_fifo_advance |-> $past(tokw))
    else $error("fifo advance without token clear");
endmodule // uotg_sp_asserts
bind uotg_status_power uotg_sp_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .cable_identity(cable_identity),
  .vbus_above_session(vbus_above_session), .a_device_role(a_device_role),
  .dplus_pullup_en(dplus_pullup_en), .vbus_charge_en(vbus_charge_en),
  .vbus_discharge_en(vbus_discharge_en), .usb_clk_enable(usb_clk_enable),
  .pins_owned(pins_owned), .sleep_block(sleep_block),
  .status_fifo_advance(status_fifo_advance)
);
`default_nettype wire

// >>> dv/uotg_cable_model.sv
/* Far-side cable model: turns a line mode into synchronous line levels.
   Assumes pclk; mode 0 idle J, 1 K state, 2 single-ended zero, 3 traffic. */
`timescale 1ns/1ns
`default_nettype none
module uotg_cable_model (
  input wire logic pclk,
  input wire logic [1:0] mode,
  output logic szero = 1'b0,
  output logic jst = 1'b1,
  output logic kst = 1'b0,
  output logic act = 1'b0
);
  logic ph = 1'b0;
  // Traffic alternates J and K each cycle so no state holds long
  always @(posedge pclk)
  begin
    ph <= !ph;
    szero <= mode == 2'd2;
    jst <= mode == 2'd0 || (mode == 2'd3 && ph);
    kst <= mode == 2'd1 || (mode == 2'd3 && !ph);
    act <= mode[0];
  end
endmodule // uotg_cable_model
`default_nettype wire

// >>> dv/uotg_status_power_tb.sv
/* Testbench for uotg_status_power: APB master, cable model, self-checks.
   Assumes a 20 MHz pclk and the register map of the constants header. */
`timescale 1ns/1ns
`default_nettype none
module uotg_status_power_tb;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, r, lf = 32'h00016817;
  logic cid = 1'b1, vb = 1'b0, ar = 1'b0, hm = 1'b0;
  logic [3:0] hw = 4'h0;
  logic [5:0] ev = 6'h00;
  logic [7:0] eev = 8'h00, een = 8'h00, d, e, host = 8'he8;
  logic [1:0] lm = 2'd0;
  wire [31:0] prdata;
  wire pready, pslverr, sz, js, ks, act, clk_en, lowp, pins, slp, adv;
  wire [3:0] res;
  wire [2:0] vbo;
  int bad_count = 0, total_checks = 0, adv_cnt = 0, i, n;
  int eidx [8] = '{0, 1, 2, 3, 4, 5, 4, 2};
  logic [7:0] fexp [8] = '{8'h80, 8'h08, 8'h04, 8'h04, 8'h01, 8'h01, 8'h00, 8'h00};
  uotg_status_power uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cable_identity(cid), .vbus_above_session(vb), .a_device_role(ar),
    .single_ended_zero(sz), .j_state_indication(js), .k_state_indication(ks),
    .host_mode_enable(hm), .bus_activity(act), .hw_dplus_pullup(hw[3]),
    .hw_dminus_pullup(hw[2]), .hw_dplus_pulldown(hw[1]), .hw_dminus_pulldown(hw[0]),
    .stall_handshake(ev[0]), .token_finished(ev[1]), .sof_received(ev[2]),
    .sof_threshold(ev[3]), .bus_reset_seen(ev[4]), .detach_seen(ev[5]),
    .error_events(eev), .error_enables(een), .dplus_pullup_en(res[3]),
    .dminus_pullup_en(res[2]), .dplus_pulldown_en(res[1]), .dminus_pulldown_en(res[0]),
    .vbus_power_on(vbo[2]), .vbus_charge_en(vbo[1]), .vbus_discharge_en(vbo[0]),
    .usb_clk_enable(clk_en), .xcvr_low_power(lowp), .pins_owned(pins),
    .sleep_block(slp), .status_fifo_advance(adv)
  );
  uotg_cable_model u_cable (.pclk(pclk), .mode(lm), .szero(sz), .jst(js), .kst(ks),
    .act(act));
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] st_exp(input logic c, input logic v, input logic a);
    return {24'h0, c, 3'b000, v, !v && !a, 1'b0, v && a};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dt};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk)
    if (adv === 1'b1)
      adv_cnt <= adv_cnt + 1;
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    repeat (80000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 32'h4, 0);
    chk(r, 0);
    apb(0, 32'hc, 0);
    chk(r, 0);
    apb(1, 32'h8, 8'h01);
    apb(0, 32'h8, 0);
    chk(r, 32'h09);
    for (i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      {cid, vb, ar} <= i[2:0];
      apb(0, 32'h0, 0);
      chk(r & 32'hffffffdf, st_exp(i[2], i[1], i[0]));
    end
    apb(1, 32'h0, 8'hff);
    apb(0, 32'h0, 0);
    chk(r & 32'hffffffdf, st_exp(cid, vb, ar));
    apb(0, 32'h10, 0);
    chk(err, 1);
    chk(r, 0);
    for (i = 0; i < 10; i++)
    begin
      lf = nx(lf);
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : lf[7:0];
      @(posedge pclk);
      hw <= lf[11:8];
      apb(1, 32'h4, d);
      repeat (2) @(negedge pclk);
      chk(res, d[2] ? d[7:4] : lf[11:8]);
      chk(vbo, {d[3], d[1:0]});
      apb(0, 32'h4, 0);
      chk(r, d);
    end
    apb(1, 32'hc, 8'hff);
    for (i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      hm <= host[i];
      @(posedge pclk);
      ev <= 6'h01 << eidx[i];
      @(posedge pclk);
      ev <= 6'h00;
      apb(0, 32'hc, 0);
      chk(r & 32'h8f, fexp[i]);
      n = adv_cnt;
      apb(1, 32'hc, 8'h8f);
      repeat (2) @(negedge pclk);
      chk(adv_cnt - n, i == 1);
    end
    for (i = 0; i < 6; i++)
    begin
      lf = nx(lf);
      d = (i == 0) ? 8'h00 : lf[7:0];
      e = (i == 0) ? 8'hff : lf[15:8];
      @(posedge pclk);
      een <= d;
      eev <= e;
      @(posedge pclk);
      eev <= 8'h00;
      apb(0, 32'hc, 0);
      chk(r & 32'h02, {|(d & e), 1'b0});
      apb(1, 32'hc, 8'h02);
    end
    apb(1, 32'h8, 8'h03);
    repeat (2) @(negedge pclk);
    chk({clk_en, lowp}, 2'b01);
    apb(1, 32'h8, 8'h11);
    @(posedge pclk);
    lm <= 2'd3;
    repeat (4) @(negedge pclk);
    chk({clk_en, lowp, slp}, 3'b101);
    apb(0, 32'h8, 0);
    chk(r, 32'h99);
    apb(1, 32'h8, 8'h01);
    @(posedge pclk);
    lm <= 2'd0;
    repeat (2) @(negedge pclk);
    chk(slp, 0);
    apb(0, 32'h8, 0);
    chk(r, 32'h09);
    apb(1, 32'h8, 8'h00);
    apb(0, 32'h8, 0);
    chk(r & 32'h08, 32'h08);
    repeat (8) @(posedge pclk);
    ev <= 6'h01;
    @(posedge pclk);
    ev <= 6'h00;
    apb(0, 32'h8, 0);
    chk(r, 0);
    chk({pins, res, vbo, clk_en}, 0);
    apb(0, 32'hc, 0);
    chk(r & 32'h8f, 0);
    apb(1, 32'h8, 8'h01);
    apb(1, 32'hc, 8'hff);
    // Resume interrupt is never enabled by this bench
    @(posedge pclk);
    hm <= 1'b0;
    lm <= 2'd1;
    repeat (40) @(posedge pclk);
    lm <= 2'd0;
    apb(0, 32'hc, 0);
    chk(r & 32'h60, 0);
    @(posedge pclk);
    lm <= 2'd1;
    repeat (60) @(posedge pclk);
    lm <= 2'd0;
    apb(0, 32'hc, 0);
    chk(r & 32'h60, 32'h20);
    apb(1, 32'hc, 8'hff);
    @(posedge pclk);
    hm <= 1'b1;
    repeat (60) @(posedge pclk);
    apb(0, 32'hc, 0);
    chk(r & 32'h40, 32'h40);
    @(posedge pclk);
    lm <= 2'd1;
    @(posedge pclk);
    lm <= 2'd0;
    apb(1, 32'hc, 8'hff);
    repeat (19000) @(posedge pclk);
    apb(0, 32'h0, 0);
    chk(r & 32'h20, 0);
    repeat (1200) @(posedge pclk);
    apb(0, 32'h0, 0);
    chk(r & 32'h20, 32'h20);
    repeat (38000) @(posedge pclk);
    apb(0, 32'hc, 0);
    chk(r & 32'h10, 0);
    repeat (2000) @(posedge pclk);
    apb(0, 32'hc, 0);
    chk(r & 32'h10, 32'h10);
    give_verdict();
  end
endmodule // uotg_status_power_tb
`default_nettype wire
